// [bench/cmf_can_sink.sv]
// CAN controller model: takes frames in order and keeps them.
// Assumes one frame word of ext, id, length and data.
`timescale 1ns/1ps
module cmf_can_sink (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Pace and frames
  input  wire logic        slow,
  input  wire logic        frm_valid,
  output logic             frm_ready,
  input  wire logic [97:0] frm_word
);
  logic [97:0] got[$];
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      frm_ready <= 1'b0;
    else
    begin
      if (frm_valid && frm_ready)
        got.push_back(frm_word);
      frm_ready <= slow ? !frm_ready : 1'b1;
    end
  end
endmodule

// [bench/cmf_props.sv]
// Port checker for the measurement message framer.
// Assumes the default register map with GCFG at byte address 0x00.
`timescale 1ns/1ps
module cmf_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // Register port and samples
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        samp_valid,
  // Frame side
  input wire logic        frm_valid,
  input wire logic        frm_ready,
  input wire logic        frm_ext,
  input wire logic [28:0] frm_id,
  input wire logic [3:0]  frm_dlc,
  input wire logic [63:0] frm_data,
  input wire logic [2:0]  can_bitrate,
  input wire logic        can_ack_ignore
);
  logic meas, seen, samp_seen;
  wire  gcfg_wr = reg_wr && reg_addr == 8'h00;
  // Shadow of mode and sample history
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meas      <= 1'b0;
      seen      <= 1'b0;
      samp_seen <= 1'b0;
    end
    else
    begin
      meas      <= gcfg_wr ? reg_wdata[0] : meas;
      seen      <= seen | gcfg_wr;
      samp_seen <= (gcfg_wr && !reg_wdata[0]) ? 1'b0 : samp_seen | (samp_valid & meas);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_hold;
    frm_valid && !frm_ready && !(gcfg_wr && !reg_wdata[0])
      |=> frm_valid && $stable(frm_data) && $stable(frm_id) && $stable(frm_dlc);
  endproperty
  a_hold: assert property (p_hold) else $error("frame changed before accept");
  property p_meas;
    frm_valid |-> meas;
  endproperty
  a_meas: assert property (p_meas) else $error("frame outside measurement");
  property p_cause;
    frm_valid |-> samp_seen;
  endproperty
  a_cause: assert property (p_cause) else $error("frame without sample");
  property p_dlc;
    frm_valid |-> frm_dlc <= 4'h8;
  endproperty
  a_dlc: assert property (p_dlc) else $error("length above eight");
  property p_fill;
    frm_valid |-> (frm_data >> {frm_dlc, 3'b000}) == 64'h0;
  endproperty
  a_fill: assert property (p_fill) else $error("bytes past length not zero");
  property p_std;
    frm_valid && !frm_ext |-> frm_id[28:11] == 18'h0;
  endproperty
  a_std: assert property (p_std) else $error("standard id too wide");
  property p_dflt;
    !seen |-> can_bitrate == 3'h2 && can_ack_ignore;
  endproperty
  a_dflt: assert property (p_dflt) else $error("bus defaults wrong");
  property p_set;
    gcfg_wr |=> can_bitrate == $past(reg_wdata[6:4]) && can_ack_ignore == $past(reg_wdata[2]);
  endproperty
  a_set: assert property (p_set) else $error("bus settings not taken");
endmodule
bind cmf_framer cmf_props i_props (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .samp_valid(samp_valid), .frm_valid(frm_valid),
  .frm_ready(frm_ready), .frm_ext(frm_ext), .frm_id(frm_id), .frm_dlc(frm_dlc),
  .frm_data(frm_data), .can_bitrate(can_bitrate), .can_ack_ignore(can_ack_ignore));

// [bench/tb.sv]
// Testbench for the measurement message framer.
// Assumes the CAN controller model and the port checker.
`timescale 1ns/1ps
module tb;
  logic         ref_clk, nrst, reg_wr, reg_rd, samp_valid, slow;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata;
  logic [127:0] samp_data;
  logic         frm_valid, frm_ready, frm_ext, can_ack_ignore;
  logic [28:0]  frm_id;
  logic [3:0]   frm_dlc;
  logic [63:0]  frm_data;
  logic [2:0]   can_bitrate;
  logic [97:0]  exp_q[$];
  int           errors, checks_done;
  localparam logic [97:0] F0 = {1'b0, 29'h123, 4'h8, 64'h0000_7FFE_78D6_1234};
  localparam logic [97:0] F1 = {1'b0, 29'h5EF, 4'h2, 64'hBEEF};
  localparam logic [97:0] X0 = {1'b1, 29'h123, 4'h8, 64'h0000_7FFE_78D6_1234};
  localparam logic [97:0] X1 = {1'b1, 29'h1ABCDEF, 4'h2, 64'hBEEF};
  cmf_framer i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .samp_valid(samp_valid),
    .samp_data(samp_data), .frm_valid(frm_valid), .frm_ready(frm_ready), .frm_ext(frm_ext),
    .frm_id(frm_id), .frm_dlc(frm_dlc), .frm_data(frm_data), .can_bitrate(can_bitrate),
    .can_ack_ignore(can_ack_ignore));
  cmf_can_sink i_sink (.ref_clk(ref_clk), .nrst(nrst), .slow(slow), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm_word({frm_ext, frm_id, frm_dlc, frm_data}));
  task automatic check(input logic [97:0] got, input logic [97:0] exp, input string what);
  begin
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
  begin
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, exp, "read");
    @(posedge ref_clk);
  end
  endtask
  task automatic sample;
  begin
    samp_data  <= {64'h0, 16'hBEEF, 16'hFFFE, 16'h5678, 16'h1234};
    samp_valid <= 1'b1;
    @(posedge ref_clk);
    samp_valid <= 1'b0;
    repeat (6) @(posedge ref_clk);
  end
  endtask
  task automatic drain(input int n);
    int i;
  begin
    for (i = 0; i < 400 && i_sink.got.size() < n; i++)
      @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
    check(i_sink.got.size(), n, "frame count");
    while (i_sink.got.size() > 0 && exp_q.size() > 0)
      check(i_sink.got.pop_front(), exp_q.pop_front(), "frame");
    i_sink.got.delete();
    exp_q.delete();
  end
  endtask
  task automatic test_done;
  begin
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    #80000;
    errors++;
    test_done;
  end
  initial
  begin
    {nrst, reg_wr, reg_rd, samp_valid, slow, reg_addr, reg_wdata, samp_data} = '0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00, 32'h24);
    rd(8'h04, 32'h1);
    rd(8'h20, 32'h0);
    wr(8'h00, 32'h30);
    rd(8'h00, 32'h30);
    check(can_bitrate, 3'h3, "bitrate");
    $display("registers done");
    wr(8'h00, 32'h25);
    wr(8'h40, 32'h123);
    wr(8'h44, 32'hF3);
    wr(8'h48, 32'h9110A000);
    wr(8'h4C, 32'h80318220);
    wr(8'h50, 32'h1ABCDEF);
    wr(8'h54, 32'h23);
    wr(8'h58, 32'hA300);
    wr(8'h64, 32'h81);
    slow <= 1'b1;
    exp_q = '{F0, F1};
    sample;
    drain(2);
    slow <= 1'b0;
    wr(8'h00, 32'h27);
    exp_q = '{X0, X1};
    sample;
    drain(2);
    $display("packing done");
    wr(8'h04, 32'h3);
    exp_q = '{X0, X1, X0, X1};
    repeat (6) sample;
    drain(4);
    $display("divider done");
    wr(8'h04, 32'h1);
    wr(8'h54, 32'h0);
    wr(8'h00, 32'h26);
    sample;
    drain(0);
    wr(8'h00, 32'h27);
    exp_q = '{X0};
    sample;
    drain(1);
    rd(8'h08, 32'h9);
    $display("mode done");
    test_done;
  end
endmodule

// [common/cmf_defs.vh]
// Constants for the measurement message framer.
// Assumes byte addresses on an 8-bit register port with 32-bit words.
`ifndef CMF_DEFS_VH
`define CMF_DEFS_VH
// Register offsets
`define CMF_REG_GCFG      8'h00
`define CMF_REG_RATE      8'h04
`define CMF_REG_STAT      8'h08
`define CMF_SLOT_SEL      2'h1
`define CMF_SLOT_ID       2'h0
`define CMF_SLOT_CTRL     2'h1
`define CMF_SLOT_MAP0     2'h2
`define CMF_SLOT_MAP1     2'h3
// Global configuration fields
`define CMF_GCFG_MEAS     0
`define CMF_GCFG_EXT      1
`define CMF_GCFG_ACKIGN   2
`define CMF_GCFG_BR_LO    4
`define CMF_GCFG_BR_HI    6
`define CMF_BR_500K       3'h2
// Slot control fields
`define CMF_CTRL_EXISTS   0
`define CMF_CTRL_ACTIVE   1
`define CMF_CTRL_DLC_LO   4
`define CMF_CTRL_DLC_HI   7
// Channel map field layout
`define CMF_MAP_OFF_HI    5
`define CMF_MAP_CH_LO     8
`define CMF_MAP_CH_HI     10
`define CMF_MAP_BE        12
`define CMF_MAP_SIGN      13
`define CMF_MAP_EN        15
`define CMF_MAX_OFF       6'h30
`define CMF_SIGN_FLIP     16'h8000
`define CMF_MAX_DLC       4'h8
// Sizes
`define CMF_NUM_SLOTS     4
`define CMF_FIELDS        4
`define CMF_FRAME_W       98
`define CMF_RATE_RST      16'h0001
`endif

// [logic/cmf_framer.v]
// Measurement message framer: slot registers, send-rate divider, frame packer, frame FIFO.
// Assumes one clock, sample strobe synchronous to ref_clk, CAN controller drains frames.
`timescale 1ns/1ps
`include "cmf_defs.vh"

module cmf_fifo #(
  parameter WIDTH = 98,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             nrst,
  input  wire             flush,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign level     = count;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule

module cmf_framer #(
  parameter NUM_CH     = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // Clock and reset
  input  wire                 ref_clk,
  input  wire                 nrst,
  // Register port
  input  wire [7:0]           reg_addr,
  input  wire [31:0]          reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [31:0]          reg_rdata,
  // Sample source
  input  wire                 samp_valid,
  input  wire [NUM_CH*16-1:0] samp_data,
  // CAN controller frame side
  output wire                 frm_valid,
  input  wire                 frm_ready,
  output wire                 frm_ext,
  output wire [28:0]          frm_id,
  output wire [3:0]           frm_dlc,
  output wire [63:0]          frm_data,
  // CAN controller settings
  output wire [2:0]           can_bitrate,
  output wire                 can_ack_ignore
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SCAN = 1'b1;

  reg  [31:0]          gcfg;
  reg  [15:0]          rate;
  reg  [15:0]          div_cnt;
  reg  [15:0]          sent_cnt;
  reg  [7:0]           skip_cnt;
  reg  [28:0]          slot_id   [0:`CMF_NUM_SLOTS-1];
  reg  [7:0]           slot_ctrl [0:`CMF_NUM_SLOTS-1];
  reg  [63:0]          slot_map  [0:`CMF_NUM_SLOTS-1];
  reg  [NUM_CH*16-1:0] samp_hold;
  reg                  state;
  reg  [1:0]           scan_idx;
  reg  [31:0]          next_rdata;
  wire                 meas;
  wire                 slot_sel;
  wire [1:0]           slot_n;
  wire [1:0]           slot_reg;
  wire [15:0]          rate_eff;
  wire                 trigger;
  wire                 slot_ok;
  wire                 fifo_in_ready;
  wire                 fifo_out_valid;
  wire [FIFO_AW:0]     fifo_level;
  wire [63:0]          part_acc [0:`CMF_FIELDS];
  wire [63:0]          byte_mask;
  wire [3:0]           dlc_raw;
  wire [3:0]           dlc_eff;
  wire [28:0]          id_eff;
  wire [97:0]          frame_in;
  wire [97:0]          frame_out;
  integer              k;

  assign meas     = gcfg[`CMF_GCFG_MEAS];
  assign slot_sel = (reg_addr[7:6] == `CMF_SLOT_SEL);
  assign slot_n   = reg_addr[5:4];
  assign slot_reg = reg_addr[3:2];
  assign rate_eff = (rate == 16'h0000) ? `CMF_RATE_RST : rate;
  assign trigger  = meas && samp_valid && (div_cnt + 1'b1 >= rate_eff);
  assign slot_ok  = slot_ctrl[scan_idx][`CMF_CTRL_EXISTS] &&
                    slot_ctrl[scan_idx][`CMF_CTRL_ACTIVE];
  assign can_bitrate    = gcfg[`CMF_GCFG_BR_HI:`CMF_GCFG_BR_LO];
  assign can_ack_ignore = gcfg[`CMF_GCFG_ACKIGN];

  // Per-field packing
  assign part_acc[0] = 64'h0;
  genvar g;
  generate
    for (g = 0; g < `CMF_FIELDS; g = g + 1)
    begin : g_field
      wire [15:0] f;
      wire [2:0]  ch;
      wire [15:0] raw;
      wire [15:0] enc;
      wire [15:0] ord;
      wire [63:0] part;
      assign f   = slot_map[scan_idx][16*g +: 16];
      assign ch  = f[`CMF_MAP_CH_HI:`CMF_MAP_CH_LO];
      assign raw = samp_hold[{ch, 4'h0} +: 16];
      assign enc = f[`CMF_MAP_SIGN] ? raw : (raw ^ `CMF_SIGN_FLIP);
      assign ord = f[`CMF_MAP_BE] ? {enc[7:0], enc[15:8]} : enc;
      assign part = (f[`CMF_MAP_EN] && (f[`CMF_MAP_OFF_HI:0] <= `CMF_MAX_OFF)) ?
                    ({48'h0, ord} << f[`CMF_MAP_OFF_HI:0]) : 64'h0;
      assign part_acc[g+1] = part_acc[g] | part;
    end
  endgenerate

  assign dlc_raw = slot_ctrl[scan_idx][`CMF_CTRL_DLC_HI:`CMF_CTRL_DLC_LO];
  assign dlc_eff = (dlc_raw > `CMF_MAX_DLC) ? `CMF_MAX_DLC : dlc_raw;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_mask
      assign byte_mask[8*g +: 8] = (g < dlc_eff) ? 8'hFF : 8'h00;
    end
  endgenerate

  assign id_eff   = gcfg[`CMF_GCFG_EXT] ? slot_id[scan_idx] :
                    {18'h0, slot_id[scan_idx][10:0]};
  assign frame_in = {gcfg[`CMF_GCFG_EXT], id_eff, dlc_eff,
                     part_acc[`CMF_FIELDS] & byte_mask};

  assign frm_valid = fifo_out_valid && meas;
  assign frm_ext   = frame_out[97];
  assign frm_id    = frame_out[96:68];
  assign frm_dlc   = frame_out[67:64];
  assign frm_data  = frame_out[63:0];

  cmf_fifo #(
    .WIDTH (`CMF_FRAME_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .flush     (!meas),
    .in_valid  ((state == ST_SCAN) && slot_ok && meas),
    .in_ready  (fifo_in_ready),
    .in_data   (frame_in),
    .out_valid (fifo_out_valid),
    .out_ready (frm_ready && meas),
    .out_data  (frame_out),
    .level     (fifo_level)
  );

  // Register read mux
  always @*
  begin
    next_rdata = 32'h0;
    if (slot_sel)
    begin
      case (slot_reg)
        `CMF_SLOT_ID:   next_rdata = {3'h0, slot_id[slot_n]};
        `CMF_SLOT_CTRL: next_rdata = {24'h0, slot_ctrl[slot_n]};
        `CMF_SLOT_MAP0: next_rdata = slot_map[slot_n][31:0];
        default:        next_rdata = slot_map[slot_n][63:32];
      endcase
    end
    else
    begin
      case (reg_addr)
        `CMF_REG_GCFG: next_rdata = gcfg;
        `CMF_REG_RATE: next_rdata = {16'h0, rate};
        `CMF_REG_STAT: next_rdata = {2'h0, fifo_level[4:0], state, skip_cnt,
                                     sent_cnt};
        default:       next_rdata = 32'h0;
      endcase
    end
  end

  // Registers and scan engine
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gcfg      <= {25'h0, `CMF_BR_500K, 1'b0, 1'b1, 2'h0};
      rate      <= `CMF_RATE_RST;
      div_cnt   <= 16'h0;
      sent_cnt  <= 16'h0;
      skip_cnt  <= 8'h0;
      samp_hold <= {(NUM_CH*16){1'b0}};
      state     <= ST_IDLE;
      scan_idx  <= 2'h0;
      reg_rdata <= 32'h0;
      for (k = 0; k < `CMF_NUM_SLOTS; k = k + 1)
      begin
        slot_id[k]   <= 29'h0;
        slot_ctrl[k] <= 8'h0;
        slot_map[k]  <= 64'h0;
      end
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0;
      if (reg_wr && !slot_sel)
      begin
        if (reg_addr == `CMF_REG_GCFG)
          gcfg <= {25'h0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
        if (reg_addr == `CMF_REG_RATE)
          rate <= reg_wdata[15:0];
      end
      if (reg_wr && slot_sel)
      begin
        case (slot_reg)
          `CMF_SLOT_ID:   slot_id[slot_n] <= reg_wdata[28:0];
          `CMF_SLOT_CTRL: slot_ctrl[slot_n] <= reg_wdata[`CMF_CTRL_EXISTS] ?
                                               {reg_wdata[7:4], 2'h0, reg_wdata[1:0]} : 8'h0;
          `CMF_SLOT_MAP0: slot_map[slot_n][31:0] <= reg_wdata;
          default:        slot_map[slot_n][63:32] <= reg_wdata;
        endcase
      end
      if (frm_valid && frm_ready)
        sent_cnt <= sent_cnt + 1'b1;
      if (!meas)
      begin
        state   <= ST_IDLE;
        div_cnt <= 16'h0;
      end
      else
      begin
        if (samp_valid)
          div_cnt <= trigger ? 16'h0 : div_cnt + 1'b1;
        if (trigger && state == ST_SCAN)
          skip_cnt <= skip_cnt + 1'b1;
        case (state)
          ST_IDLE:
          begin
            if (trigger)
            begin
              samp_hold <= samp_data;
              scan_idx  <= 2'h0;
              state     <= ST_SCAN;
            end
          end
          ST_SCAN:
          begin
            if (!slot_ok || fifo_in_ready)
            begin
              scan_idx <= scan_idx + 1'b1;
              if (scan_idx == 2'h3)
                state <= ST_IDLE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
